// ===== rtl/pwr_state_pkg.sv
// Purpose: Constants and types for the memory power-state tracker
// Assumes: 100 MHz sys_clk; pins sampled synchronously on rising edges
// Notes:   Timing figures are plain defaults, not any part's values
//
// Overview of operation
// RULE_01: Power-down entry on CKE high-to-low with chip select high.
// RULE_02: Controller keeps CKE high during mode register, read, write.
// RULE_03: Entry allowed mid activate/precharge/refresh; low current after finish.
// RULE_04: Power-down is idle if all banks idle, otherwise active.
// RULE_05: In power-down only clock and CKE heard; other inputs ignored.
// RULE_06: Controller holds CKE each level at least the minimum pulse time.
// RULE_07: No refresh inside power-down; controller bounds its stay.
// RULE_08: Exit on CKE high; executable commands only after exit latency.
// RULE_09: Clock may stop in power-down; stable two cycles before exit.
// RULE_10: Read to power-down entry spacing kept by the controller.
// RULE_11: Write to power-down entry spacing kept by the controller.
// RULE_12: Activate, precharge, refresh to entry spacing kept by controller.
// RULE_13: Mode register read to entry spacing kept by the controller.
// RULE_14: Mode register write to entry spacing kept by the controller.
// RULE_15: Deep power-down on CKE falling with chip select low, CA 1,1,0.
// RULE_16: Banks idle, bus quiet, CKE low throughout deep power-down.
// RULE_17: Deep power-down shuts buffers and supplies; array may be lost.
// RULE_18: Deep power-down exit on CKE high; full initialisation needed.
// RULE_19: Clock stop with CKE low after activates and precharges complete.
// RULE_20: Only refresh may run while clock stopped; clock valid before exit.
// RULE_21: Stopped clock held with true line low, complement high.
// RULE_22: Clock change with CKE high; usable after two cycles plus tXP.
// RULE_23: Chip select and CKE sampled only on rising edges.
// RULE_24: NOP is chip select high, or low with CA0..CA2 all high.
// RULE_25: Deep power-down exit detected on CKE rise, not a command.
package pwr_state_pkg;

  localparam int unsigned CLK_PERIOD_PS = 10000;
  // Exit latency and background operation time, picoseconds
  localparam int unsigned T_XP_PS      = 7500;
  localparam int unsigned T_BGOP_PS    = 90000;
  // Exit latency rounds up (least time)
  localparam int unsigned XP_CYC_INT =
    (T_XP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned BG_CYC_INT =
    (T_BGOP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CLK_OK_CYC_INT = 2;
  localparam logic [7:0] XP_CYC     = 8'(XP_CYC_INT);
  localparam logic [7:0] BG_CYC     = 8'(BG_CYC_INT);
  localparam logic [7:0] CLK_OK_CYC = 8'(CLK_OK_CYC_INT);
  localparam int unsigned NUM_BANKS = 8;

  // Power states, one-hot
  typedef enum logic [3:0] {
    ST_ACTIVE = 4'h1,
    ST_PD     = 4'h2,
    ST_DPD    = 4'h4,
    ST_EXIT   = 4'h8
  } pwr_state_type;

  // Pin group sampled at each rising edge
  typedef struct packed {
    logic       cke;
    logic       cs_b;
    logic [2:0] ca;
  } cmd_pins_type;

  // Status outputs
  typedef struct packed {
    logic in_pd;
    logic pd_active;
    logic pd_low_power;
    logic in_dpd;
    logic need_init;
    logic cmd_ready;
    logic buf_en;
    logic array_valid;
  } pwr_status_type;

  localparam pwr_status_type STATUS_RST = '{
    in_pd: 1'b0, pd_active: 1'b0, pd_low_power: 1'b0, in_dpd: 1'b0,
    need_init: 1'b1, cmd_ready: 1'b0, buf_en: 1'b1, array_valid: 1'b0};

endpackage

// ===== rtl/pwr_state_ctl.sv
// Purpose: Power-down and deep power-down state tracking of the memory
// Assumes: All pins synchronous to sys_clk; one rising edge per sample
// Notes:   Other command decoding lives elsewhere; banks reported by core
`timescale 1ns/1ps
module pwr_state_ctl (
  input  wire logic                           sys_clk,
  input  wire logic                           rst_b,
  input  wire logic                           clk_en,
  input  wire pwr_state_pkg::cmd_pins_type    pins,
  input  wire logic [pwr_state_pkg::NUM_BANKS-1:0] bank_open,
  input  wire logic                           bg_start,
  input  wire logic                           init_done,
  output pwr_state_pkg::pwr_status_type       status
);

  typedef struct packed {
    pwr_state_pkg::pwr_state_type   st;
    logic                           cke_prev;
    logic [7:0]                     cnt;
    logic [7:0]                     bg_cnt;
    pwr_state_pkg::pwr_status_type  stat;
  } state_type;

  state_type cur_q;
  state_type cur_d;
  logic      is_nop;
  logic      pd_entry;
  logic      dpd_entry;
  logic      bg_busy;

  // Command-level decode on the sampled pins
  always_comb
  begin
    is_nop    = pins.cs_b | (pins.ca == 3'h7); // RULE_24
    pd_entry  = cur_q.cke_prev & ~pins.cke & pins.cs_b; // RULE_01 RULE_23
    dpd_entry = cur_q.cke_prev & ~pins.cke & ~pins.cs_b
                & (pins.ca == 3'h3); // RULE_15
    bg_busy   = (cur_q.bg_cnt != 8'h00);
  end

  // Next-state logic
  always_comb
  begin
    cur_d = cur_q;
    cur_d.cke_prev = pins.cke; // RULE_23
    // Background row/refresh work finishes even in power-down
    if (bg_start && cur_q.st == pwr_state_pkg::ST_ACTIVE)
    begin
      cur_d.bg_cnt = pwr_state_pkg::BG_CYC; // RULE_03
    end
    else if (bg_busy)
    begin
      cur_d.bg_cnt = cur_q.bg_cnt - 8'h01; // RULE_03
    end
    unique case (cur_q.st)
      pwr_state_pkg::ST_ACTIVE:
      begin
        cur_d.stat.cmd_ready = 1'b1;
        if (init_done)
        begin
          cur_d.stat.need_init = 1'b0;
          cur_d.stat.array_valid = 1'b1;
        end
        if (dpd_entry)
        begin
          cur_d.st = pwr_state_pkg::ST_DPD;
          cur_d.stat.in_dpd = 1'b1;
          cur_d.stat.buf_en = 1'b0; // RULE_17
          cur_d.stat.array_valid = 1'b0; // RULE_17
          cur_d.stat.need_init = 1'b1; // RULE_18
          cur_d.stat.cmd_ready = 1'b0;
          cur_d.bg_cnt = 8'h00;
        end
        else if (pd_entry)
        begin
          cur_d.st = pwr_state_pkg::ST_PD;
          cur_d.stat.in_pd = 1'b1;
          cur_d.stat.pd_active = |bank_open; // RULE_04
          cur_d.stat.buf_en = 1'b0; // RULE_05
          cur_d.stat.cmd_ready = 1'b0;
          cur_d.stat.pd_low_power = 1'b0;
        end
      end
      pwr_state_pkg::ST_PD:
      begin
        // Only CKE is heard; low current once background work ends
        cur_d.stat.pd_low_power = ~bg_busy; // RULE_03 RULE_07
        if (pins.cke)
        begin
          cur_d.st = pwr_state_pkg::ST_EXIT; // RULE_08
          cur_d.cnt = pwr_state_pkg::XP_CYC;
          cur_d.stat.in_pd = 1'b0;
          cur_d.stat.pd_low_power = 1'b0;
          cur_d.stat.buf_en = 1'b1;
        end
      end
      pwr_state_pkg::ST_DPD:
      begin
        if (pins.cke)
        begin
          // Level seen on CKE alone, no command decode
          cur_d.st = pwr_state_pkg::ST_EXIT; // RULE_25 RULE_18
          cur_d.cnt = pwr_state_pkg::XP_CYC + pwr_state_pkg::CLK_OK_CYC; // RULE_22
          cur_d.stat.in_dpd = 1'b0;
          cur_d.stat.buf_en = 1'b1;
        end
      end
      pwr_state_pkg::ST_EXIT:
      begin
        // Commands refused until exit latency has run out
        if (cur_q.cnt <= 8'h01)
        begin
          cur_d.st = pwr_state_pkg::ST_ACTIVE; // RULE_08
          cur_d.cnt = 8'h00;
          cur_d.stat.pd_active = 1'b0;
          cur_d.stat.cmd_ready = 1'b1;
        end
        else
        begin
          cur_d.cnt = cur_q.cnt - 8'h01;
        end
      end
      default:
      begin
        cur_d.st = pwr_state_pkg::ST_ACTIVE;
      end
    endcase
    if (!is_nop && cur_q.st == pwr_state_pkg::ST_EXIT)
    begin
      cur_d.stat.cmd_ready = 1'b0; // RULE_08
    end
  end

  // State register with clock enable
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      cur_q.st       <= pwr_state_pkg::ST_ACTIVE;
      cur_q.cke_prev <= 1'b0;
      cur_q.cnt      <= 8'h00;
      cur_q.bg_cnt   <= 8'h00;
      cur_q.stat     <= pwr_state_pkg::STATUS_RST;
    end
    else if (clk_en)
    begin
      cur_q <= cur_d;
    end
  end

  assign status = cur_q.stat;

endmodule

// ===== bench/pwr_state_sva.sv
// Purpose: Checker for the power-state tracker status outputs
// Assumes: One clock domain; status changes one edge after sampling
// Notes:   cke_q mirrors the tracker's own copy of the previous CKE
`timescale 1ns/1ps
module pwr_state_sva (
  input wire logic                                sys_clk,
  input wire logic                                rst_b,
  input wire logic                                clk_en,
  input wire pwr_state_pkg::cmd_pins_type         pins,
  input wire logic [pwr_state_pkg::NUM_BANKS-1:0] bank_open,
  input wire logic                                bg_start,
  input wire logic                                init_done,
  input wire pwr_state_pkg::pwr_status_type       status
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic cke_q;
  logic entry;
  // Previous CKE, frozen while clk_en is low
  always_ff @(posedge sys_clk)
    cke_q <= rst_b ? (clk_en ? pins.cke : cke_q) : 1'b0;
  // CKE falling seen from the running state
  // Exit latency excluded: cmd_ready is low there and entry is not decoded
  assign entry = clk_en && cke_q && !pins.cke && status.buf_en &&
                 status.cmd_ready && !status.in_pd && !status.in_dpd;
  a_pd_entry: assert property (entry && pins.cs_b |=> status.in_pd &&
    !status.buf_en && (status.pd_active == $past(|bank_open)))
    else $error("power-down entry wrong");
  a_dpd_entry: assert property (entry && !pins.cs_b && pins.ca == 3'h3
    |=> status.in_dpd && !status.array_valid && status.need_init)
    else $error("deep power-down entry wrong");
  a_pd_ignore: assert property (clk_en && status.in_pd && !pins.cke
    |=> status.in_pd && !status.buf_en)
    else $error("power-down left while CKE low");
  a_pd_exit: assert property (clk_en && status.in_pd && pins.cke
    |=> !status.in_pd && status.buf_en && !status.cmd_ready)
    else $error("power-down exit wrong");
  a_xp: assert property ($fell(status.in_pd) && clk_en && pins.cs_b
    |=> status.cmd_ready)
    else $error("commands not ready after exit latency");
  a_dpd_hold: assert property (clk_en && status.in_dpd && !pins.cke
    |=> status.in_dpd && !status.array_valid)
    else $error("deep power-down not held");
  a_dpd_exit: assert property (clk_en && status.in_dpd && pins.cke
    |=> !status.in_dpd && status.need_init)
    else $error("deep power-down exit wrong");
  a_low_power: assert property (status.pd_low_power |-> status.in_pd)
    else $error("low power outside power-down");
  a_freeze: assert property (!clk_en |=> $stable(status))
    else $error("status moved with clk_en low");
endmodule
bind pwr_state_ctl pwr_state_sva chk (.sys_clk(sys_clk), .rst_b(rst_b),
  .clk_en(clk_en), .pins(pins), .bank_open(bank_open),
  .bg_start(bg_start), .init_done(init_done), .status(status));

// ===== bench/ctl_model.sv
// Purpose: Controller model driving CKE, chip select and CA
// Assumes: Pins change at falling edges of sys_clk
// Notes:   Deselected CA shows the inverse of the last value
`timescale 1ns/1ps
module ctl_model (
  input  wire logic                   sys_clk,
  output pwr_state_pkg::cmd_pins_type pins
);
  initial pins = '{cke: 1'b1, cs_b: 1'b1, ca: 3'h7};
  // Callers space commands and keep the clock running and stable
  // One pin cycle, then NOP cycles holding the CKE level
  task automatic send(input logic cke, input logic cs_b,
                      input logic [2:0] ca, input int nops);
    @(negedge sys_clk);
    pins = '{cke: cke, cs_b: cs_b, ca: ca};
    repeat (nops)
    begin
      @(negedge sys_clk);
      pins = '{cke: cke, cs_b: 1'b1, ca: ~ca};
    end
  endtask
endmodule

// ===== bench/tb_top.sv
// Purpose: Self-checking bench for the power-state tracker
// Assumes: Inputs change at falling edges; ctl_model drives the pins
// Notes:   Background work runs BG_CYC cycles after bg_start
`timescale 1ns/1ps
module tb_top;
  logic                                sys_clk, rst_b, clk_en;
  logic                                bg_start, init_done;
  logic [pwr_state_pkg::NUM_BANKS-1:0] bank_open;
  pwr_state_pkg::cmd_pins_type         pins;
  pwr_state_pkg::pwr_status_type       status;
  int                                  fail_count, samples_checked;
  // Clock, and all inputs except the ctl_model pins at time zero
  initial
  begin
    {sys_clk, rst_b, clk_en, bg_start, init_done, bank_open} = '0;
    forever #5 sys_clk = ~sys_clk;
  end
  ctl_model ctl (.sys_clk(sys_clk), .pins(pins));
  pwr_state_ctl dut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
    .pins(pins), .bank_open(bank_open), .bg_start(bg_start),
    .init_done(init_done), .status(status));
  task automatic chk(input string name, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic t_idle_pd();
    ctl.send(1'b0, 1'b1, 3'h7, 2);
    chk("in_pd", 1'b1, status.in_pd);
    chk("buf_en", 1'b0, status.buf_en);
    chk("pd_active", 1'b0, status.pd_active);
    chk("pd_low_power", 1'b1, status.pd_low_power);
    ctl.send(1'b0, 1'b0, 3'h3, 1);
    chk("in_dpd", 1'b0, status.in_dpd);
    ctl.send(1'b1, 1'b1, 3'h7, 1);
    chk("in_pd", 1'b0, status.in_pd);
    chk("cmd_ready", 1'b0, status.cmd_ready);
    @(negedge sys_clk);
    chk("cmd_ready", 1'b1, status.cmd_ready);
    $display("idle power-down done");
  endtask
  task automatic t_active_pd();
    bank_open = 8'h01;
    bg_start = 1'b1;
    @(negedge sys_clk);
    bg_start = 1'b0;
    ctl.send(1'b0, 1'b1, 3'h7, 2);
    chk("pd_active", 1'b1, status.pd_active);
    chk("pd_low_power", 1'b0, status.pd_low_power);
    repeat (pwr_state_pkg::BG_CYC_INT) @(negedge sys_clk);
    chk("pd_low_power", 1'b1, status.pd_low_power);
    ctl.send(1'b1, 1'b1, 3'h7, 2);
    bank_open = 8'h00;
    $display("active power-down done");
  endtask
  task automatic t_dpd();
    ctl.send(1'b0, 1'b0, 3'h3, 2);
    chk("in_dpd", 1'b1, status.in_dpd);
    chk("array_valid", 1'b0, status.array_valid);
    ctl.send(1'b1, 1'b1, 3'h7, 4);
    chk("in_dpd", 1'b0, status.in_dpd);
    chk("need_init", 1'b1, status.need_init);
    init_done = 1'b1;
    @(negedge sys_clk);
    init_done = 1'b0;
    chk("need_init", 1'b0, status.need_init);
    $display("deep power-down done");
  endtask
  task automatic t_freeze();
    clk_en = 1'b0;
    ctl.send(1'b0, 1'b1, 3'h7, 1);
    chk("in_pd", 1'b0, status.in_pd);
    clk_en = 1'b1;
    ctl.send(1'b1, 1'b1, 3'h7, 3);
    $display("freeze done");
  endtask
  // Reset, then the scenarios in turn
  initial
  begin
    repeat (6) @(negedge sys_clk);
    rst_b = 1'b1;
    clk_en = 1'b1;
    repeat (2) @(negedge sys_clk);
    t_idle_pd();
    t_active_pd();
    t_dpd();
    t_freeze();
    end_of_test();
  end
  // Watchdog far beyond the expected run
  initial
  begin
    #20us;
    fail_count++;
    end_of_test();
  end
endmodule
